// [rtl/sigath_top.v]
// interrupt gather: peripheral levels to one core interrupt, AXI4-Lite registers
// assumes sources are levels held by their modules until serviced there
`include "sigath_map.vh"
`default_nettype none
module sigath_top (
    input  wire        CLK,
    input  wire        RESET,
    input  wire [9:0]  DMA_CHANNEL_IRQ,
    input  wire [3:0]  HOST_PORT_INTERFACE_IRQ,
    input  wire        ETHERNET_CHANNEL_RX_IRQ,
    input  wire        ETHERNET_CHANNEL_TX_IRQ,
    input  wire        SERIAL_MODULE1_RX_IRQ,
    input  wire        SERIAL_MODULE1_TX_IRQ,
    input  wire        SERIAL_MODULE2_RX_IRQ,
    input  wire        SERIAL_MODULE2_TX_IRQ,
    input  wire        WATCHDOG_IRQ,
    input  wire        TIMER1_IRQ,
    input  wire        TIMER2_IRQ,
    input  wire [3:0]  THIRD_GPIO_PORT_IRQ,
    input  wire [31:0] S_AXI_AWADDR,
    input  wire [2:0]  S_AXI_AWPROT,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [31:0] S_AXI_ARADDR,
    input  wire [2:0]  S_AXI_ARPROT,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    output reg         CORE_IRQ,
    output reg         GATHER_EVENT_IRQ
);
    wire [31:0] src_async;
    wire [31:0] raw_sync;
    reg  [31:0] raw_reg;
    reg  [31:0] enable_reg;
    reg  [31:0] enable_next;
    reg  [31:0] enabled_view;
    reg  [`SIG_EV_W-1:0] ev_mask_reg;
    wire [`SIG_EV_W-1:0] ev_stat;
    reg  [`SIG_EV_W-1:0] ev_set;
    reg  [`SIG_EV_W-1:0] ev_clr;
    reg         core_irq_prev_reg;
    reg         core_irq_now;

    reg         aw_held_reg;
    reg  [31:0] aw_addr_reg;
    reg         w_held_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    wire        wr_fire;
    reg  [1:0]  wr_resp;
    integer     i;

    // dma channels 1..10 on bits 31..22
    assign src_async[`SIG_DMA_HI:`SIG_DMA_LO] = {DMA_CHANNEL_IRQ[0], DMA_CHANNEL_IRQ[1],
        DMA_CHANNEL_IRQ[2], DMA_CHANNEL_IRQ[3], DMA_CHANNEL_IRQ[4], DMA_CHANNEL_IRQ[5],
        DMA_CHANNEL_IRQ[6], DMA_CHANNEL_IRQ[7], DMA_CHANNEL_IRQ[8], DMA_CHANNEL_IRQ[9]};
    // dma channel 3 bit
    // channel 1 is index 0, so bits 30 and 29 carry channels 2 and 3
    // host ports and ethernet
    assign src_async[`SIG_HPI_HI:`SIG_HPI_LO] = {HOST_PORT_INTERFACE_IRQ[0], HOST_PORT_INTERFACE_IRQ[1],
        HOST_PORT_INTERFACE_IRQ[2], HOST_PORT_INTERFACE_IRQ[3]};
    assign src_async[`SIG_ETH_RX] = ETHERNET_CHANNEL_RX_IRQ;
    assign src_async[`SIG_ETH_TX] = ETHERNET_CHANNEL_TX_IRQ;
    assign src_async[`SIG_SER1_RX] = SERIAL_MODULE1_RX_IRQ;
    assign src_async[`SIG_SER1_TX] = SERIAL_MODULE1_TX_IRQ;
    assign src_async[`SIG_SER2_RX] = SERIAL_MODULE2_RX_IRQ;
    assign src_async[`SIG_SER2_TX] = SERIAL_MODULE2_TX_IRQ;
    assign src_async[11:7] = 5'h00;
    assign src_async[`SIG_WDOG] = WATCHDOG_IRQ;
    assign src_async[`SIG_TMR1] = TIMER1_IRQ;
    assign src_async[`SIG_TMR2] = TIMER2_IRQ;
    assign src_async[`SIG_GPIO_HI:`SIG_GPIO_LO] = THIRD_GPIO_PORT_IRQ;

    // gpio pins arrive asynchronous; sync all for uniform latency
    sigath_sync #(
        .W (32)
    ) u_sync (
        .clk   (CLK),
        .reset (RESET),
        .d     (src_async),
        .q     (raw_sync)
    );

    always @(posedge CLK) begin
        if (RESET) begin
            raw_reg <= `SIG_ZERO32;
        end else begin
            raw_reg <= raw_sync & `SIG_USED_MASK;
        end
    end

    always @* begin
        enabled_view = raw_reg & enable_reg;
        core_irq_now = |enabled_view;
    end

    always @(posedge CLK) begin
        if (RESET) begin
            CORE_IRQ          <= 1'b0;
            core_irq_prev_reg <= 1'b0;
        end else begin
            CORE_IRQ          <= core_irq_now;
            core_irq_prev_reg <= core_irq_now;
        end
    end

    // write channel: address and data taken in either order
    assign wr_fire = aw_held_reg && w_held_reg && !S_AXI_BVALID;

    always @(posedge CLK) begin
        if (RESET) begin
            aw_held_reg   <= 1'b0;
            aw_addr_reg   <= `SIG_ZERO32;
            w_held_reg    <= 1'b0;
            w_data_reg    <= `SIG_ZERO32;
            w_strb_reg    <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `SIG_RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= !aw_held_reg && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
            S_AXI_WREADY  <= !w_held_reg && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_resp;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // decode of the held write
    always @* begin
        enable_next = enable_reg;
        ev_clr      = `SIG_EV_RST;
        wr_resp     = `SIG_RESP_OKAY;
        case (aw_addr_reg & 32'hFFFFFFFC)
            `SIG_OFF_ENABLE: begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (w_strb_reg[i]) begin
                        enable_next[i*8 +: 8] = w_data_reg[i*8 +: 8];
                    end
                end
                enable_next = enable_next & `SIG_USED_MASK;
            end
            `SIG_OFF_ENABLED: begin
                wr_resp = `SIG_RESP_OKAY;
            end
            `SIG_OFF_RAW: begin
                wr_resp = `SIG_RESP_OKAY;
            end
            `SIG_OFF_ISTAT: begin
                if (w_strb_reg[0]) begin
                    ev_clr = w_data_reg[`SIG_EV_W-1:0];
                end
            end
            `SIG_OFF_IMASK: begin
                wr_resp = `SIG_RESP_OKAY;
            end
            default: begin
                wr_resp = `SIG_RESP_SLVERR;
            end
        endcase
        if (!wr_fire) begin
            enable_next = enable_reg;
            ev_clr      = `SIG_EV_RST;
        end
    end

    always @(posedge CLK) begin
        if (RESET) begin
            enable_reg  <= `SIG_ENABLE_RST;
            ev_mask_reg <= `SIG_EV_RST;
        end else begin
            enable_reg <= enable_next;
            if (wr_fire && ((aw_addr_reg & 32'hFFFFFFFC) == `SIG_OFF_IMASK) && w_strb_reg[0]) begin
                ev_mask_reg <= w_data_reg[`SIG_EV_W-1:0];
            end
        end
    end

    // core-line edges as sticky events; set beats clear
    always @* begin
        ev_set                = `SIG_EV_RST;
        ev_set[`SIG_EV_RISE]  = core_irq_now && !core_irq_prev_reg;
        ev_set[`SIG_EV_FALL]  = !core_irq_now && core_irq_prev_reg;
    end

    sigath_sticky #(
        .W (`SIG_EV_W)
    ) u_sticky (
        .clk   (CLK),
        .reset (RESET),
        .set   (ev_set),
        .clr   (ev_clr),
        .q     (ev_stat)
    );

    always @(posedge CLK) begin
        if (RESET) begin
            GATHER_EVENT_IRQ <= 1'b0;
        end else begin
            GATHER_EVENT_IRQ <= |(ev_stat & ev_mask_reg);
        end
    end

    // read channel, one outstanding
    always @(posedge CLK) begin
        if (RESET) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= `SIG_ZERO32;
            S_AXI_RRESP   <= `SIG_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= `SIG_RESP_OKAY;
                case (S_AXI_ARADDR & 32'hFFFFFFFC)
                    `SIG_OFF_ENABLE: begin
                        S_AXI_RDATA <= enable_reg;
                    end
                    `SIG_OFF_ENABLED: begin
                        S_AXI_RDATA <= enabled_view;
                    end
                    `SIG_OFF_RAW: begin
                        S_AXI_RDATA <= raw_reg;
                    end
                    `SIG_OFF_ISTAT: begin
                        S_AXI_RDATA <= {30'h00000000, ev_stat};
                    end
                    `SIG_OFF_IMASK: begin
                        S_AXI_RDATA <= {30'h00000000, ev_mask_reg};
                    end
                    default: begin
                        S_AXI_RDATA <= `SIG_ZERO32;
                        S_AXI_RRESP <= `SIG_RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/sigath_map.vh]
// register map, field positions and reset values of the interrupt gather block
// assumes a 32-bit aligned word per register on an AXI4-Lite slave
`ifndef SIGATH_MAP_VH
`define SIGATH_MAP_VH
`define SIG_ADDR_W          32
`define SIG_DATA_W          32
`define SIG_OFF_ENABLE      32'hFFB00030
`define SIG_OFF_ENABLED     32'hFFB00034
`define SIG_OFF_RAW         32'hFFB00038
`define SIG_OFF_ISTAT       32'hFFB00040
`define SIG_OFF_IMASK       32'hFFB00044
`define SIG_ENABLE_RST      32'h00000000
`define SIG_ZERO32          32'h00000000
`define SIG_USED_MASK       32'hFFFFF07F
`define SIG_DMA_HI          31
`define SIG_DMA_LO          22
`define SIG_HPI_HI          21
`define SIG_HPI_LO          18
`define SIG_ETH_RX          17
`define SIG_ETH_TX          16
`define SIG_SER1_RX         15
`define SIG_SER1_TX         14
`define SIG_SER2_RX         13
`define SIG_SER2_TX         12
`define SIG_WDOG            6
`define SIG_TMR1            5
`define SIG_TMR2            4
`define SIG_GPIO_HI         3
`define SIG_GPIO_LO         0
`define SIG_EV_W            2
`define SIG_EV_RISE         0
`define SIG_EV_FALL         1
`define SIG_EV_RST          2'h0
`define SIG_RESP_OKAY       2'h0
`define SIG_RESP_SLVERR     2'h2
`endif

// [rtl/sigath_sync.v]
// two-flop synchroniser for a bus of asynchronous levels
// assumes inputs come from other clock domains or pins
`default_nettype none
module sigath_sync #(
    parameter W = 32
) (
    input  wire         clk,
    input  wire         reset,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_reg;
    // first stage read only by the second
    always @(posedge clk) begin
        if (reset) begin
            meta_reg <= {W{1'b0}};
            q        <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// [rtl/sigath_sticky.v]
// sticky event bits: set wins over write-one-to-clear
// assumes clear vector is a one-cycle write strobe
`default_nettype none
module sigath_sticky #(
    parameter W = 2
) (
    input  wire         clk,
    input  wire         reset,
    input  wire [W-1:0] set,
    input  wire [W-1:0] clr,
    output reg  [W-1:0] q
);
    always @(posedge clk) begin
        if (reset) begin
            q <= {W{1'b0}};
        end else begin
            q <= set | (q & ~clr);
        end
    end
endmodule
`default_nettype wire

// [sim/sigath_src_model.sv]
// source model: peripheral interrupt levels, one bit per source in register layout
// assumes the bench pulses set and clear vectors for one cycle
`default_nettype none
module sigath_src_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [31:0] set_vec,
    input  wire logic [31:0] clr_vec,
    output logic      [9:0]  dma,
    output logic      [3:0]  hpi,
    output logic      [31:0] lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk) begin
        if (reset) begin
            lvl <= 32'h00000000;
        end else begin
            lvl <= (lvl | set_vec) & ~clr_vec;
        end
    end
    assign dma = {<<{lvl[31:22]}};
    // host port one on bit 21
    assign hpi = {<<{lvl[21:18]}};
endmodule
`default_nettype wire

// [sim/sigath_checker.sv]
// checker: bus timing and core interrupt relations at the gather block ports
// assumes one clock and a synchronous active-high reset
`default_nettype none
module sigath_checker (
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic        CORE_IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wrote_reg;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    // no write yet means enable mask still zero
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wrote_reg <= 1'b0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            wrote_reg <= 1'b1;
        end
    end
    sequence wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence rd_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    reset_quiet_a: assert property ($fell(RESET) |-> !S_AXI_BVALID && !S_AXI_RVALID && !CORE_IRQ)
        else $error("outputs not quiet after reset");
    irq_needs_enable_a: assert property (!wrote_reg |-> !CORE_IRQ)
        else $error("core irq without any enable");
    write_answer_a: assert property (wr_taken |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    read_answer_a: assert property (rd_taken |=> S_AXI_RVALID)
        else $error("read data late");
    bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    unused_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[11:7] == 5'h00)
        else $error("unused bits read nonzero");
    busy_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while response pending");
endmodule
bind sigath_top sigath_checker i_sigath_checker (.*);
`default_nettype wire

// [sim/sigath_test.sv]
// bench for the interrupt gather block: registers, bit map, masking, events
// assumes the source model stands in for every peripheral interrupt output
`include "sigath_map.vh"
`default_nettype none
module sigath_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OKR = `SIG_RESP_OKAY;
    logic        CLK, RESET, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
    logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic        CORE_IRQ, GATHER_EVENT_IRQ;
    logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA, set_vec, clr_vec, lvl;
    logic [3:0]  S_AXI_WSTRB, hpi;
    logic [2:0]  S_AXI_AWPROT, S_AXI_ARPROT;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    logic [9:0]  dma;
    int          bad_count, n_checks;
    sigath_top i_sigath_top (.*, .DMA_CHANNEL_IRQ(dma), .HOST_PORT_INTERFACE_IRQ(hpi),
        .ETHERNET_CHANNEL_RX_IRQ(lvl[17]), .ETHERNET_CHANNEL_TX_IRQ(lvl[16]), .SERIAL_MODULE1_RX_IRQ(lvl[15]),
        .SERIAL_MODULE1_TX_IRQ(lvl[14]), .SERIAL_MODULE2_RX_IRQ(lvl[13]), .SERIAL_MODULE2_TX_IRQ(lvl[12]),
        .WATCHDOG_IRQ(lvl[6]), .TIMER1_IRQ(lvl[5]), .TIMER2_IRQ(lvl[4]), .THIRD_GPIO_PORT_IRQ(lvl[3:0]));
    sigath_src_model i_sigath_src_model (.clk(CLK), .reset(RESET), .set_vec(set_vec), .clr_vec(clr_vec),
        .dma(dma), .hpi(hpi), .lvl(lvl));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic src(input logic [31:0] s, input logic [31:0] c);
        set_vec <= s;
        clr_vec <= c;
        @(posedge CLK);
        set_vec <= 32'h00000000;
        clr_vec <= 32'h00000000;
        // margin over sync plus register delay
        repeat (8) @(posedge CLK);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic aw_p;
        logic w_p;
        int n;
        aw_p = 1'b1;
        w_p = 1'b1;
        n = 0;
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        while ((aw_p || w_p) && n < 40) begin
            @(posedge CLK);
            n++;
            if (aw_p && S_AXI_AWREADY === 1'b1) begin
                aw_p = 1'b0;
                S_AXI_AWVALID <= 1'b0;
            end
            if (w_p && S_AXI_WREADY === 1'b1) begin
                w_p = 1'b0;
                S_AXI_WVALID <= 1'b0;
            end
        end
        // late ready so the response has to stand
        do begin
            @(posedge CLK);
            n++;
        end while (S_AXI_BVALID !== 1'b1 && n < 80);
        S_AXI_BREADY <= 1'b1;
        @(posedge CLK);
        S_AXI_BREADY <= 1'b0;
        chk("write resp", {30'h0, er}, {30'h0, S_AXI_BRESP});
    endtask
    task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (S_AXI_ARREADY !== 1'b1 && n < 40);
        S_AXI_ARVALID <= 1'b0;
        do begin
            @(posedge CLK);
            n++;
        end while (S_AXI_RVALID !== 1'b1 && n < 80);
        S_AXI_RREADY <= 1'b1;
        @(posedge CLK);
        S_AXI_RREADY <= 1'b0;
        chk(nm, e, S_AXI_RDATA);
        chk("read resp", {30'h0, er}, {30'h0, S_AXI_RRESP});
    endtask
    task automatic ck1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic t_reset();
        src(32'hFFFFFFFF, 32'h00000000);
        rc("enable", `SIG_OFF_ENABLE, 32'h00000000, OKR);
        rc("raw", `SIG_OFF_RAW, `SIG_USED_MASK, OKR);
        rc("enabled", `SIG_OFF_ENABLED, 32'h00000000, OKR);
        ck1("core irq", 1'b0, CORE_IRQ);
        src(32'h00000000, 32'hFFFFFFFF);
        $display("reset test done");
    endtask
    task automatic t_map();
        logic [31:0] b;
        wr(`SIG_OFF_ENABLE, 32'hFFFFFFFF, 4'hF, OKR);
        rc("enable", `SIG_OFF_ENABLE, `SIG_USED_MASK, OKR);
        for (int i = 0; i < 32; i++) begin
            b = 32'h00000001 << i;
            if ((b & `SIG_USED_MASK) != 32'h0) begin
                src(b, 32'h00000000);
                rc("raw bit", `SIG_OFF_RAW, b, OKR);
                rc("enabled bit", `SIG_OFF_ENABLED, b, OKR);
                ck1("core irq", 1'b1, CORE_IRQ);
                src(32'h00000000, b);
                ck1("core irq", 1'b0, CORE_IRQ);
            end
        end
        $display("bit map test done");
    endtask
    task automatic t_mask();
        src(32'h80000011, 32'h00000000);
        wr(`SIG_OFF_ENABLE, 32'h00000010, 4'hF, OKR);
        rc("raw", `SIG_OFF_RAW, 32'h80000011, OKR);
        rc("enabled", `SIG_OFF_ENABLED, 32'h00000010, OKR);
        ck1("core irq", 1'b1, CORE_IRQ);
        wr(`SIG_OFF_ENABLE, 32'h00000000, 4'hF, OKR);
        rc("enabled", `SIG_OFF_ENABLED, 32'h00000000, OKR);
        ck1("core irq", 1'b0, CORE_IRQ);
        src(32'h00000000, 32'hFFFFFFFF);
        $display("mask test done");
    endtask
    task automatic t_ro();
        src(32'h00400020, 32'h00000000);
        wr(`SIG_OFF_ENABLE, 32'h00F00000, 4'hF, OKR);
        wr(`SIG_OFF_RAW, 32'h00000000, 4'hF, OKR);
        wr(`SIG_OFF_ENABLED, 32'hFFFFFFFF, 4'hF, OKR);
        rc("raw", `SIG_OFF_RAW, 32'h00400020, OKR);
        rc("enabled", `SIG_OFF_ENABLED, 32'h00400000, OKR);
        rc("enable", `SIG_OFF_ENABLE, 32'h00F00000, OKR);
        wr(`SIG_OFF_ENABLE, 32'hFFFFFFFF, 4'h1, OKR);
        rc("enable lane", `SIG_OFF_ENABLE, 32'h00F0007F, OKR);
        rc("enabled", `SIG_OFF_ENABLED, 32'h00400020, OKR);
        rc("unmapped", 32'hFFB0003C, 32'h00000000, `SIG_RESP_SLVERR);
        wr(32'hFFB0003C, 32'hFFFFFFFF, 4'hF, `SIG_RESP_SLVERR);
        src(32'h00000000, 32'hFFFFFFFF);
        $display("read-only test done");
    endtask
    task automatic t_event();
        // earlier tests left core-line edges latched; start from a clean status
        wr(`SIG_OFF_ISTAT, 32'h00000003, 4'hF, OKR);
        rc("event status", `SIG_OFF_ISTAT, 32'h00000000, OKR);
        wr(`SIG_OFF_IMASK, 32'h00000003, 4'hF, OKR);
        wr(`SIG_OFF_ENABLE, 32'h00000001, 4'hF, OKR);
        src(32'h00000001, 32'h00000000);
        rc("event status", `SIG_OFF_ISTAT, 32'h00000001, OKR);
        ck1("event irq", 1'b1, GATHER_EVENT_IRQ);
        wr(`SIG_OFF_IMASK, 32'h00000000, 4'hF, OKR);
        rc("event status", `SIG_OFF_ISTAT, 32'h00000001, OKR);
        ck1("event irq", 1'b0, GATHER_EVENT_IRQ);
        wr(`SIG_OFF_ISTAT, 32'h00000001, 4'hF, OKR);
        wr(`SIG_OFF_IMASK, 32'h00000003, 4'hF, OKR);
        src(32'h00000000, 32'h00000001);
        rc("event status", `SIG_OFF_ISTAT, 32'h00000002, OKR);
        ck1("event irq", 1'b1, GATHER_EVENT_IRQ);
        wr(`SIG_OFF_ISTAT, 32'h00000003, 4'hF, OKR);
        rc("event status", `SIG_OFF_ISTAT, 32'h00000000, OKR);
        ck1("event irq", 1'b0, GATHER_EVENT_IRQ);
        $display("event test done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        bad_count++;
        close_out();
    end
    initial begin
        RESET = 1'b1;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, set_vec, clr_vec} = 160'h0;
        {S_AXI_WSTRB, S_AXI_AWPROT, S_AXI_ARPROT} = 10'h000;
        bad_count = 0;
        n_checks = 0;
        repeat (20) @(posedge CLK);
        RESET <= 1'b0;
        repeat (2) @(posedge CLK);
        t_reset();
        t_map();
        t_mask();
        t_ro();
        t_event();
        close_out();
    end
endmodule
`default_nettype wire
